// ### hdl/link_power_pkg.sv
// Constants, register map and types for the link power status monitor
package link_power_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SENSE_LOW_RESET_NS = 2600;
  localparam int SENSE_LOW_DISABLE_NS = 26000;
  localparam int SENSE_RESET_CYC_I = (SENSE_LOW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SENSE_DIS_CYC_I = SENSE_LOW_DISABLE_NS / CLK_PERIOD_NS;
  localparam int LOW_CNT_W = 9;
  localparam logic [LOW_CNT_W-1:0] SENSE_RESET_CYC = LOW_CNT_W'(SENSE_RESET_CYC_I);
  localparam logic [LOW_CNT_W-1:0] SENSE_DIS_CYC = LOW_CNT_W'(SENSE_DIS_CYC_I);
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] PORT_CFG_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;
  // Control register fields
  localparam int CTRL_LINK_ACTIVE_BIT = 0;
  localparam logic CTRL_LINK_ACTIVE_RST = 1'b1;
  // Port config: three fields of one bit per port, each field 8 bits apart
  localparam int PCFG_DISABLED_POS = 0;
  localparam int PCFG_HARD_POS = 8;
  localparam int PCFG_SLEEP_EN_POS = 16;
  // Status fields
  localparam int STAT_SENSE_BIT = 0;
  localparam int STAT_SELFID_BIT = 1;
  localparam int STAT_STATE_POS = 4;
  localparam int STAT_CABLE_DIS_POS = 8;
  localparam int STAT_ALL_DIS_BIT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    IF_ACTIVE = 3'h1,
    IF_LP_RESET = 3'h2,
    IF_LP_DISABLED = 3'h4
  } ifState_t;

  typedef struct packed {
    logic disconnected;
    logic asleep;
    logic dsConnected;
    logic active;
    logic dcConnected;
  } portStatus_t;
endpackage

// ### hdl/link_power_status_monitor.sv
// Link power sense monitor, PHY-link interface state and cable-power control
`timescale 1ns/1ps
module link_power_status_monitor #(
  parameter int NPORTS = 3
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic linkPowerSense,
  input wire logic linkServiceRequest,
  input wire logic wideLinkModeSelect,
  input wire logic [1:0] ctlFromCore,
  input wire logic [7:0] dataFromCore,
  input wire link_power_pkg::portStatus_t [NPORTS-1:0] portStatus,
  output logic [1:0] interfaceControlLines,
  output logic [7:0] interfaceData,
  output logic requestToCore,
  output logic interfaceClockRun,
  output logic interfaceClockFast,
  output logic selfIdLinkActive,
  output logic [NPORTS-1:0] cablePowerDisable,
  input wire logic awvalid,
  output logic awready,
  input wire logic [link_power_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [link_power_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import link_power_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  ifState_t state_q, state_d;
  logic [LOW_CNT_W-1:0] lowCnt_q, lowCnt_d;
  logic linkActiveCtl_q, linkActiveCtl_d;
  logic [NPORTS-1:0] portDisabled_q, portDisabled_d;
  logic [NPORTS-1:0] portHard_q, portHard_d;
  logic [NPORTS-1:0] portSleepEn_q, portSleepEn_d;
  logic [1:0] ctl_q, ctl_d;
  logic [7:0] data_q, data_d;
  logic clkRun_q, clkRun_d;
  logic clkFast_q, clkFast_d;
  logic selfId_q, selfId_d;
  logic [NPORTS-1:0] cableDis_q, cableDis_d;
  logic awHeld_q, awHeld_d;
  logic [ADDR_W-1:0] awAddr_q, awAddr_d;
  logic wHeld_q, wHeld_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic senseActive;
  logic [31:0] statusWord;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == CTRL_OFFSET || a == PORT_CFG_OFFSET || a == STATUS_OFFSET;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Power sense filtering and interface state
  // Input sampled once per 100 ns cycle, so a high shorter than that may be missed
  assign senseActive = linkPowerSense || (lowCnt_q <= SENSE_RESET_CYC);

  always_comb begin
    lowCnt_d = lowCnt_q;
    state_d = state_q;
    if (linkPowerSense) begin
      lowCnt_d = '0;
      state_d = IF_ACTIVE;
    end else begin
      if (lowCnt_q <= SENSE_DIS_CYC) begin
        lowCnt_d = lowCnt_q + 1'b1; // Saturates just past the disable limit
      end
      if (lowCnt_q > SENSE_DIS_CYC) begin
        state_d = IF_LP_DISABLED;
      end else if (lowCnt_q > SENSE_RESET_CYC) begin
        state_d = IF_LP_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interface outputs, self-ID state and cable power
  always_comb begin
    ctl_d = '0;
    data_d = '0;
    clkRun_d = 1'b1;
    clkFast_d = wideLinkModeSelect;
    if (state_q == IF_ACTIVE) begin
      ctl_d = ctlFromCore;
      data_d = dataFromCore;
    end
    if (state_q == IF_LP_DISABLED) begin
      clkRun_d = 1'b0;
    end
    selfId_d = senseActive && linkActiveCtl_q;
    for (int p = 0; p < NPORTS; p++) begin
      cableDis_d[p] = portStatus[p].disconnected || portStatus[p].asleep
        || (portStatus[p].dsConnected && !portStatus[p].active);
      cableDis_d[p] = cableDis_d[p] || (portDisabled_q[p] && portHard_q[p])
        || (portDisabled_q[p] && portSleepEn_q[p]);
      // Dc-connected or active ports keep power unless software disabled them with hard or sleep enable also set
      if ((portStatus[p].dcConnected || portStatus[p].active)
          && !(portDisabled_q[p] && (portHard_q[p] || portSleepEn_q[p]))) begin
        cableDis_d[p] = 1'b0;
      end
    end
  end

  // Request only forwarded while the interface is active
  assign requestToCore = linkServiceRequest && (state_q == IF_ACTIVE);
  assign interfaceControlLines = ctl_q;
  assign interfaceData = data_q;
  assign interfaceClockRun = clkRun_q;
  assign interfaceClockFast = clkFast_q;
  assign selfIdLinkActive = selfId_q;
  assign cablePowerDisable = cableDis_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave
  always_comb begin
    statusWord = '0;
    statusWord[STAT_SENSE_BIT] = senseActive;
    statusWord[STAT_SELFID_BIT] = selfId_q;
    statusWord[STAT_STATE_POS +: 3] = state_q;
    statusWord[STAT_CABLE_DIS_POS +: NPORTS] = cableDis_q;
    statusWord[STAT_ALL_DIS_BIT] = &cableDis_q;
  end

  assign awready = !awHeld_q && !bvalid_q;
  assign wready = !wHeld_q && !bvalid_q;
  assign arready = !rvalid_q;

  always_comb begin
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    wa = awHeld_q ? awAddr_q : awaddr;
    wd = wHeld_q ? wData_q : wdata;
    ws = wHeld_q ? wStrb_q : wstrb;
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d = wHeld_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    linkActiveCtl_d = linkActiveCtl_q;
    portDisabled_d = portDisabled_q;
    portHard_d = portHard_q;
    portSleepEn_d = portSleepEn_q;
    if (awvalid && awready) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if ((awHeld_q || (awvalid && awready)) && (wHeld_q || (wvalid && wready))
        && !bvalid_q) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      if (wa == CTRL_OFFSET && ws[0]) begin
        linkActiveCtl_d = wd[CTRL_LINK_ACTIVE_BIT];
      end
      if (wa == PORT_CFG_OFFSET) begin
        if (ws[0]) portDisabled_d = wd[PCFG_DISABLED_POS +: NPORTS];
        if (ws[1]) portHard_d = wd[PCFG_HARD_POS +: NPORTS];
        if (ws[2]) portSleepEn_d = wd[PCFG_SLEEP_EN_POS +: NPORTS];
      end
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d = '0;
      rresp_d = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      if (araddr == CTRL_OFFSET) begin
        rdata_d[CTRL_LINK_ACTIVE_BIT] = linkActiveCtl_q;
      end
      if (araddr == PORT_CFG_OFFSET) begin
        rdata_d[PCFG_DISABLED_POS +: NPORTS] = portDisabled_q;
        rdata_d[PCFG_HARD_POS +: NPORTS] = portHard_q;
        rdata_d[PCFG_SLEEP_EN_POS +: NPORTS] = portSleepEn_q;
      end
      if (araddr == STATUS_OFFSET) begin
        rdata_d = statusWord;
      end
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Counter starts saturated so the interface wakes only on a sensed high
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= IF_LP_DISABLED;
      lowCnt_q <= SENSE_DIS_CYC + 1'b1;
      linkActiveCtl_q <= CTRL_LINK_ACTIVE_RST;
      portDisabled_q <= '0;
      portHard_q <= '0;
      portSleepEn_q <= '0;
      ctl_q <= '0;
      data_q <= '0;
      clkRun_q <= 1'b0;
      clkFast_q <= 1'b0;
      selfId_q <= 1'b0;
      cableDis_q <= '1;
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      state_q <= state_d;
      lowCnt_q <= lowCnt_d;
      linkActiveCtl_q <= linkActiveCtl_d;
      portDisabled_q <= portDisabled_d;
      portHard_q <= portHard_d;
      portSleepEn_q <= portSleepEn_d;
      ctl_q <= ctl_d;
      data_q <= data_d;
      clkRun_q <= clkRun_d;
      clkFast_q <= clkFast_d;
      selfId_q <= selfId_d;
      cableDis_q <= cableDis_d;
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q <= wHeld_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
endmodule

// ### tb/link_power_status_monitor_sva.sv
// Port assertions for the link power status monitor
`timescale 1ns/1ps
module link_power_status_monitor_sva #(
  parameter int NPORTS = 3
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic linkPowerSense,
  input wire logic wideLinkModeSelect,
  input wire logic [7:0] dataFromCore,
  input wire link_power_pkg::portStatus_t [NPORTS-1:0] portStatus,
  input wire logic [1:0] interfaceControlLines,
  input wire logic [7:0] interfaceData,
  input wire logic requestToCore,
  input wire logic interfaceClockRun,
  input wire logic interfaceClockFast,
  input wire logic selfIdLinkActive,
  input wire logic [NPORTS-1:0] cablePowerDisable
);
  import link_power_pkg::*;
  logic [8:0] lowRun_q;
  logic [8:0] lowRun_d;
  logic [NPORTS-1:0] mustOff;
  ////////////////////////////////////////////////////////////
  // Saturates past the disable point, starts saturated like the design
  always_comb begin
    lowRun_d = linkPowerSense ? 9'h000 : lowRun_q + 9'h001;
    if (!linkPowerSense && lowRun_q == 9'h12c) lowRun_d = lowRun_q;
    for (int i = 0; i < NPORTS; i++) begin
      mustOff[i] = (portStatus[i].disconnected || portStatus[i].asleep
        || portStatus[i].dsConnected) && !portStatus[i].active && !portStatus[i].dcConnected;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) lowRun_q <= 9'h12c;
    else lowRun_q <= lowRun_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // State and request follow the low count one edge late, the registered lines and clock run one edge later still
  a_req_ignored: assert property (lowRun_q >= SENSE_RESET_CYC + 2 |-> !requestToCore)
    else $error("request passed in low-power state");
  a_lines_quiet: assert property (lowRun_q >= SENSE_RESET_CYC + 3 |->
    {interfaceControlLines, interfaceData} == 10'h000)
    else $error("interface lines not held low");
  a_short_low: assert property (lowRun_q inside {[2:SENSE_RESET_CYC + 2]} |->
    interfaceData == $past(dataFromCore))
    else $error("short low gap blocked data");
  a_clock_stop: assert property (lowRun_q >= SENSE_DIS_CYC + 3 |-> !interfaceClockRun)
    else $error("interface clock still running");
  a_clock_held: assert property (lowRun_q inside {[2:SENSE_DIS_CYC + 2]} |->
    interfaceClockRun)
    else $error("interface clock stopped early");
  a_selfid_sense: assert property (selfIdLinkActive |->
    $past(linkPowerSense || lowRun_q <= SENSE_RESET_CYC))
    else $error("link reported active without sense");
  a_rate_follow: assert property ($past(nrst) |->
    interfaceClockFast == $past(wideLinkModeSelect))
    else $error("clock rate does not follow mode");
  a_cable_off: assert property (mustOff != '0 |=>
    (cablePowerDisable & $past(mustOff)) == $past(mustOff))
    else $error("cable power left enabled");
endmodule
bind link_power_status_monitor link_power_status_monitor_sva #(.NPORTS(NPORTS)) chk (
  .clock(clock),
  .nrst(nrst),
  .linkPowerSense(linkPowerSense),
  .wideLinkModeSelect(wideLinkModeSelect),
  .dataFromCore(dataFromCore),
  .portStatus(portStatus),
  .interfaceControlLines(interfaceControlLines),
  .interfaceData(interfaceData),
  .requestToCore(requestToCore),
  .interfaceClockRun(interfaceClockRun),
  .interfaceClockFast(interfaceClockFast),
  .selfIdLinkActive(selfIdLinkActive),
  .cablePowerDisable(cablePowerDisable)
);

// ### tb/link_layer_model.sv
// Link-layer controller model driving power sense and request
`timescale 1ns/1ps
module link_layer_model (
  input wire logic clock,
  input wire logic [1:0] senseMode,
  input wire logic [7:0] lowLen,
  input wire logic reqOn,
  output logic linkPowerSense,
  output logic linkServiceRequest
);
  logic [7:0] phase = 8'h00;
  // Mode 1 static level; mode 2 one-cycle pulses, as across an isolation barrier
  always @(posedge clock) begin
    phase <= (phase >= lowLen) ? 8'h00 : phase + 8'h01;
    linkPowerSense <= senseMode == 2'h1 || (senseMode == 2'h2 && phase == 8'h00);
    linkServiceRequest <= reqOn;
  end
endmodule

// ### tb/link_power_status_monitor_tb_top.sv
// Self-checking bench for the link power status monitor
`timescale 1ns/1ps
module link_power_status_monitor_tb_top;
  import link_power_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, wideLinkModeSelect = 1'b0, reqOn = 1'b0;
  logic linkPowerSense, linkServiceRequest, requestToCore, interfaceClockRun, interfaceClockFast;
  logic selfIdLinkActive, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] ctlFromCore = 2'h0, senseMode = 2'h0, interfaceControlLines, bresp, rresp, rsp;
  logic [7:0] dataFromCore = 8'h00, lowLen = 8'h14, interfaceData;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [2:0] cablePowerDisable;
  portStatus_t [2:0] portStatus = {3{5'h10}};
  int failures = 0, compares = 0;
  always #50 clock = ~clock;
  link_power_status_monitor uut (.clock, .nrst, .linkPowerSense, .linkServiceRequest,
    .wideLinkModeSelect, .ctlFromCore, .dataFromCore, .portStatus, .interfaceControlLines,
    .interfaceData, .requestToCore, .interfaceClockRun, .interfaceClockFast, .selfIdLinkActive,
    .cablePowerDisable, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp);
  link_layer_model linkPartner (.clock, .senseMode, .lowLen, .reqOn, .linkPowerSense,
    .linkServiceRequest);
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Leading edge keeps back-to-back calls from assigning twice in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 40);
    rsp = bresp;
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      failures++;
      summarize();
    end
  endtask
  task automatic rd(input logic [3:0] a);
    int n;
    @(posedge clock);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 40);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      failures++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(STATUS_OFFSET);
    chk(v, 32'h0001_0740);
    rd(CTRL_OFFSET);
    chk(v, 32'h1);
    chk(interfaceClockRun, 1'b0);
  endtask
  task automatic t_wake();
    senseMode <= 2'h1;
    dataFromCore <= 8'h5a;
    ctlFromCore <= 2'h3;
    reqOn <= 1'b1;
    cyc(6);
    chk({interfaceClockRun, interfaceControlLines, interfaceData}, 11'h75a);
    chk({requestToCore, selfIdLinkActive}, 2'h3);
    rd(STATUS_OFFSET);
    chk(v, 32'h0001_0713);
  endtask
  task automatic t_pulse();
    senseMode <= 2'h2;
    cyc(120);
    rd(STATUS_OFFSET);
    chk(v[6:0], 7'h13);
    chk(requestToCore, 1'b1);
  endtask
  task automatic t_sleep();
    senseMode <= 2'h0;
    cyc(60);
    chk({interfaceClockRun, requestToCore, interfaceControlLines, interfaceData}, 12'h800);
    rd(STATUS_OFFSET);
    chk(v[6:0], 7'h20);
    cyc(250);
    chk(interfaceClockRun, 1'b0);
    rd(STATUS_OFFSET);
    chk(v[6:0], 7'h40);
    senseMode <= 2'h1;
    cyc(5);
    chk({interfaceClockRun, interfaceData}, 9'h15a);
  endtask
  task automatic t_ctrl();
    wr(CTRL_OFFSET, 32'h0);
    chk(rsp, RESP_OKAY);
    cyc(2);
    chk(selfIdLinkActive, 1'b0);
    wr(CTRL_OFFSET, 32'h1);
    cyc(2);
    chk(selfIdLinkActive, 1'b1);
    wideLinkModeSelect <= 1'b1;
    cyc(2);
    chk(interfaceClockFast, 1'b1);
    wideLinkModeSelect <= 1'b0;
    cyc(2);
    chk(interfaceClockFast, 1'b0);
  endtask
  task automatic t_cable();
    portStatus <= {5'h04, 5'h08, 5'h10};
    cyc(2);
    chk(cablePowerDisable, 3'h7);
    portStatus <= {5'h06, 5'h02, 5'h01};
    cyc(2);
    chk(cablePowerDisable, 3'h0);
    wr(PORT_CFG_OFFSET, 32'h0002_0107);
    cyc(2);
    chk(cablePowerDisable, 3'h3);
    rd(PORT_CFG_OFFSET);
    chk(v, 32'h0002_0107);
    rd(4'hc);
    chk(v, 32'h0);
    chk(rsp, RESP_SLVERR);
    wr(4'hc, 32'h1);
    chk(rsp, RESP_SLVERR);
  endtask
  initial begin
    cyc(6);
    nrst <= 1'b1;
    t_reset();
    t_wake();
    t_pulse();
    t_sleep();
    t_ctrl();
    t_cable();
    summarize();
  end
endmodule
